// *** design/selectable_d_or_rs_flipflop.v ***
/*
  selectable storage element: falling-edge D flip-flop or reset-priority
  reset/set latch, chosen per instance.
  assumes data, clock, set and reset arrive as outside bits (inputs, flags or
  timer bits) and are synchronised here; result drives one output bit.
*/
// Function
// - D mode copies data on falling clock
// - D mode holds while clock steady
// - RS mode reset high forces output low
// - RS mode set alone switches output on
// - both high legal, acts as reset
// - both low holds previous output
// - per-instance choice of D or RS type
// - inputs from bits, drives one bit
`timescale 1ns/10ps
`include "flipflop_map.vh"
module selectable_d_or_rs_flipflop (
  input  wire clock_in,
  input  wire rst_n_in,
  input  wire mode_rs_in,
  input  wire data_in,
  input  wire edge_clk_in,
  input  wire set_in,
  input  wire reset_in,
  output reg  state_out
);
  // operand positions in the synchroniser word
  localparam N_OPS     = 4;
  localparam IDX_DATA  = 0;
  localparam IDX_CLK   = 1;
  localparam IDX_SET   = 2;
  localparam IDX_RESET = 3;

  // edge tracker states: the last clock level that was seen
  localparam [0:0] CLK_SEEN_LOW  = 1'h0;
  localparam [0:0] CLK_SEEN_HIGH = 1'h1;

  // output actions shared by both types
  localparam [1:0] ACT_HOLD  = 2'h0;
  localparam [1:0] ACT_CLEAR = 2'h1;
  localparam [1:0] ACT_SET   = 2'h2;

  reg              rst_s1_r;
  reg              rst_s2_r;
  reg              mode_r;
  reg              prev_clk_r;
  reg              prev_clk_nxt;
  reg              clk_fall;
  reg  [1:0]       rs_act;
  reg  [1:0]       d_act;
  reg  [1:0]       act;
  reg              state_nxt;
  wire [N_OPS-1:0] clean_w;
  wire             rst_n_w;
  wire             data_w;
  wire             clk_w;
  wire             set_w;
  wire             reset_w;

  // reset/set decode; reset wins, both high is a plain reset
  function [1:0] rs_action;
    input rst_lvl;
    input set_lvl;
    begin
      case ({rst_lvl, set_lvl})
        2'h0:
          rs_action = ACT_HOLD;
        2'h1:
          rs_action = ACT_SET;
        2'h2:
          rs_action = ACT_CLEAR;
        2'h3:
          rs_action = ACT_CLEAR;
        default:
          rs_action = ACT_HOLD;
      endcase
    end
  endfunction

  // d-type decode; only a falling clock edge moves the output
  function [1:0] d_action;
    input fall;
    input data_lvl;
    begin
      case ({fall, data_lvl})
        2'h2:
          d_action = ACT_CLEAR;
        2'h3:
          d_action = ACT_SET;
        default:
          d_action = ACT_HOLD;
      endcase
    end
  endfunction

  function apply_action;
    input [1:0] action;
    input       held;
    begin
      case (action)
        ACT_CLEAR:
          apply_action = 1'h0;
        ACT_SET:
          apply_action = 1'h1;
        default:
          apply_action = held;
      endcase
    end
  endfunction

  // reset leaves through two flops so every register lets go on one edge
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_s1_r <= 1'h0;
      rst_s2_r <= 1'h0;
    end
    else
    begin
      rst_s1_r <= 1'h1;
      rst_s2_r <= rst_s1_r;
    end
  end

  assign rst_n_w = rst_s2_r;

  // every operand is an outside bit
  input_sync #(
    .WIDTH (N_OPS)
  ) u_sync (
    .clock_in  (clock_in),
    .rst_n_in  (rst_n_w),
    .raw_in    ({reset_in, set_in, edge_clk_in, data_in}),
    .clean_out (clean_w)
  );

  assign data_w  = clean_w[IDX_DATA];
  assign clk_w   = clean_w[IDX_CLK];
  assign set_w   = clean_w[IDX_SET];
  assign reset_w = clean_w[IDX_RESET];

  // type is a static per-instance choice, taken as a level
  always @(posedge clock_in or negedge rst_n_w)
  begin
    if (!rst_n_w)
    begin
      mode_r <= `MODE_D_TYPE;
    end
    else
    begin
      mode_r <= mode_rs_in;
    end
  end

  // falling edge: high seen on the last cycle, low on this one
  always @*
  begin
    prev_clk_nxt = prev_clk_r;
    clk_fall     = 1'h0;
    case (prev_clk_r)
      CLK_SEEN_LOW:
      begin
        if (clk_w)
          prev_clk_nxt = CLK_SEEN_HIGH;
      end
      CLK_SEEN_HIGH:
      begin
        if (!clk_w)
        begin
          prev_clk_nxt = CLK_SEEN_LOW;
          clk_fall     = 1'h1;
        end
      end
      default:
      begin
        prev_clk_nxt = CLK_SEEN_LOW;
      end
    endcase
  end

  // both decodes run every cycle; the type picks which one acts
  always @*
  begin
    rs_act = rs_action(reset_w, set_w);
    d_act  = d_action(clk_fall, data_w);
    case (mode_r)
      `MODE_RS_TYPE:
        act = rs_act;
      `MODE_D_TYPE:
        act = d_act;
      default:
        act = ACT_HOLD;
    endcase
    state_nxt = apply_action(act, state_out);
  end

  always @(posedge clock_in or negedge rst_n_w)
  begin
    if (!rst_n_w)
    begin
      prev_clk_r <= `CLK_RESET_VAL;
    end
    else
    begin
      prev_clk_r <= prev_clk_nxt;
    end
  end

  always @(posedge clock_in or negedge rst_n_w)
  begin
    if (!rst_n_w)
    begin
      state_out <= `OUT_RESET_VAL;
    end
    else
    begin
      state_out <= state_nxt;
    end
  end
endmodule // selectable_d_or_rs_flipflop

// *** design/flipflop_map.vh ***
/*
  constants for the selectable storage element: mode codes and reset levels.
  assumes inclusion by the storage element files only.
*/
`ifndef FLIPFLOP_MAP_VH
`define FLIPFLOP_MAP_VH
`define MODE_D_TYPE     1'h0
`define MODE_RS_TYPE    1'h1
`define OUT_RESET_VAL   1'h0
`define CLK_RESET_VAL   1'h0
`define SYNC_STAGES     3
`endif

// *** design/input_sync.v ***
/*
  three-stage synchroniser for a group of external bits; a change is passed
  on once the second and third stages agree.
  assumes one clock and the internal active-low reset copy.
*/
`timescale 1ns/10ps
module input_sync #(
  parameter WIDTH = 4
) (
  input  wire             clock_in,
  input  wire             rst_n_in,
  input  wire [WIDTH-1:0] raw_in,
  output reg  [WIDTH-1:0] clean_out
);
  reg [WIDTH-1:0] s1_r;
  reg [WIDTH-1:0] s2_r;
  reg [WIDTH-1:0] s3_r;
  genvar i;

  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s1_r <= {WIDTH{1'h0}};
      s2_r <= {WIDTH{1'h0}};
      s3_r <= {WIDTH{1'h0}};
    end
    else
    begin
      s1_r <= raw_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      always @(posedge clock_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
          clean_out[i] <= 1'h0;
        else if (s2_r[i] == s3_r[i])
          clean_out[i] <= s3_r[i];
      end
    end
  endgenerate
endmodule // input_sync

// *** bench/bit_source.sv ***
/* far-side logic bits; assumes one clock */
`timescale 1ns/10ps
module bit_source (
  input  wire       clock_in,
  input  wire [4:0] want_in,
  output reg  [4:0] bits_out = 5'h00
);
  always @(posedge clock_in) bits_out <= want_in;
endmodule // bit_source

// *** bench/flop_checker.sv ***
/* port checker; assumes bind into the storage element */
`timescale 1ns/10ps
module flop_checker (
  input wire clock_in,
  input wire rst_n_in,
  input wire mode_rs_in,
  input wire data_in,
  input wire edge_clk_in,
  input wire set_in,
  input wire reset_in,
  input wire state_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  chk_d_copy: assert property (!mode_rs_in & data_in & $fell(edge_clk_in)
    |-> ##[1:8] state_out) else $error("no copy");
  chk_d_clear: assert property (!mode_rs_in & !data_in & $fell(edge_clk_in)
    |-> ##[1:8] !state_out) else $error("no d clear");
  chk_d_hold: assert property ((!mode_rs_in & $stable(edge_clk_in))[*8]
    |-> $stable(state_out)) else $error("d output moved");
  chk_rs_hold: assert property ((mode_rs_in & !set_in & !reset_in)[*8]
    |-> $stable(state_out)) else $error("rs output moved");
  chk_rs_clear: assert property ((mode_rs_in & reset_in)[*8] |-> !state_out)
    else $error("no clear");
  chk_rs_set: assert property ((mode_rs_in & set_in & !reset_in)[*8]
    |-> state_out) else $error("no set");
  cover property (mode_rs_in & set_in & reset_in);
  cover property ($rose(state_out));
  cover property ($fell(state_out));
endmodule // flop_checker
bind selectable_d_or_rs_flipflop flop_checker u_flop_checker (
  .clock_in    (clock_in),
  .rst_n_in    (rst_n_in),
  .mode_rs_in  (mode_rs_in),
  .data_in     (data_in),
  .edge_clk_in (edge_clk_in),
  .set_in      (set_in),
  .reset_in    (reset_in),
  .state_out   (state_out)
);

// *** bench/selectable_d_or_rs_flipflop_test.sv ***
/* bench; assumes bit_source feeds the storage element */
`timescale 1ns/10ps
module selectable_d_or_rs_flipflop_test;
  reg        clock_in   = 1'h0;
  reg        rst_n_in   = 1'h0;
  reg  [4:0] w          = 5'h00;
  wire [4:0] b;
  wire       q;
  int        n_fail     = 0;
  int        n_compared = 0;
  int        t          = 0;
  always #12.5 clock_in = ~clock_in;
  bit_source u_bit_source (.clock_in(clock_in), .want_in(w), .bits_out(b));
  selectable_d_or_rs_flipflop u_selectable_d_or_rs_flipflop (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .mode_rs_in(b[4]), .data_in(b[3]), .edge_clk_in(b[2]),
    .set_in(b[1]), .reset_in(b[0]), .state_out(q));
  task summarize;
    $display("fails %0d of %0d", n_fail, n_compared);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task check(input e);
    n_compared++;
    if (q !== e)
    begin
      n_fail++;
      $display("MISMATCH %0t %h %h", $time, q, e);
    end
  endtask
  task step(input [4:0] v, input e);
    @(posedge clock_in) w <= v;
    repeat (9) @(posedge clock_in);
    #1 check(e);
  endtask
  task d_type;
    step(5'h0c, 1'h0);
    step(5'h08, 1'h1);
    step(5'h04, 1'h1);
    step(5'h00, 1'h0);
    step(5'h08, 1'h0);
    step(5'h0a, 1'h0);
  endtask
  task rs_type;
    step(5'h12, 1'h1);
    step(5'h10, 1'h1);
    step(5'h13, 1'h0);
    step(5'h12, 1'h1);
    step(5'h11, 1'h0);
    step(5'h1c, 1'h0);
    step(5'h18, 1'h0);
  endtask
  task reset_mid;
    step(5'h0c, 1'h0);
    step(5'h08, 1'h1);
    @(posedge clock_in) rst_n_in <= 1'h0;
    @(posedge clock_in) #1 check(1'h0);
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'h1;
    step(5'h08, 1'h0);
    step(5'h0c, 1'h0);
    step(5'h08, 1'h1);
  endtask
  always @(posedge clock_in)
  begin
    t++;
    if (t > 999)
    begin
      n_fail++;
      summarize;
    end
  end
  initial
  begin
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'h1;
    repeat (3) @(posedge clock_in);
    d_type;
    rs_type;
    reset_mid;
    summarize;
  end
endmodule // selectable_d_or_rs_flipflop_test
